/* File: core/dtio_consts.svh */
`ifndef DTIO_CONSTS_SVH
`define DTIO_CONSTS_SVH
// =====================================
// timing
`define CLK_NS 4
`define FILT_UNIT_NS 500000
`define FILT_UNIT_CYC (`FILT_UNIT_NS / `CLK_NS)
`define OL_UNIT_NS 100000000
`define OL_UNIT_CYC (`OL_UNIT_NS / `CLK_NS)
// =====================================
// parameter codes
`define A_IN_STAT 8'h0F
`define A_OUT_STAT 8'h10
`define A_FILT 8'h11
`define A_FDT_LVL 8'h2A
`define A_FDT_BAND 8'h2B
`define A_AUX_SEL 8'h2C
`define A_AUTO 8'h32
`define A_OL_LVL 8'h80
`define A_OL_TIME 8'h81
`define A_FN_BASE 8'h70
// =====================================
// reset values and highest aux select code
`define R_FILT 8'h0F
`define R_FDT_LVL 16'h0BB8
`define R_FDT_BAND 16'h03E8
`define R_AUX_SEL 5'h0C
`define R_OL_LVL 16'h0096
`define R_OL_TIME 16'h000A
`define AUX_MAX 5'h19
// =====================================
// terminal function codes
`define FN_AHOLD 6'h12
`define FN_RAMP 6'h13
`define FN_GAIN2 6'h14
`define FN_SEQ_L 6'h15
`define FN_SEQ_M 6'h16
`define FN_SEQ_H 6'h17
`define FN_MANUAL 6'h18
`define FN_GO 6'h19
`define FN_HOLD 6'h1A
`define FN_TRV_LO 6'h1B
`define FN_TRV_HI 6'h1C
// filtered inputs: p1-p3, rx, fx, jog, fault reset, disable
`define FILT_MASK 11'h7C7
`endif

/* File: core/dtio_pkg.sv */
package dtio_pkg;
   // =====================================
   // auto operation variants
   typedef enum logic [1:0] {
      AUTO_OFF = 2'h0,
      AUTO_A = 2'h1,
      AUTO_B = 2'h2
   } auto_e;
   // =====================================
   // status coming from the drive core
   typedef struct packed {
      logic running;
      logic ref_analog;
      logic closed_loop;
      logic traverse;
      logic step_done;
      logic iol;
      logic stall;
      logic ov;
      logic lv;
      logic oh;
      logic lost;
      logic steady;
      logic inv_line;
      logic comm_line;
      logic ssearch;
      logic ready;
      logic trv_acc;
      logic trv_dec;
      logic mmc;
      logic zspd;
      logic torq;
   } core_stat_s;
   // =====================================
   // commands to the drive core
   typedef struct packed {
      logic freq_hold;
      logic ramp_freeze;
      logic alt_gain;
      logic manual;
      logic trv_neg;
      logic trv_pos;
      logic fault_reset;
      logic out_disable;
      logic seq_run;
      logic [2:0] seq_sel;
      logic [2:0] seq_step;
   } drive_ctl_s;
endpackage : dtio_pkg

/* File: core/input_filter.sv */
`timescale 1ns/1ns
`include "dtio_consts.svh"
module input_filter #(
   parameter int W = 11,
   parameter int TICK_CYC = `FILT_UNIT_CYC
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // terminals
   input wire logic [W-1:0] raw_i,
   input wire logic [W-1:0] mask_i,
   input wire logic [7:0] k_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [31:0] cnt_q [W];
   wire [31:0] lim = 32'(k_i) * 32'(TICK_CYC);
   // =====================================
   // sync then debounce
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         s1_q <= '0;
         s2_q <= '0;
      end else begin
         s1_q <= raw_i;
         s2_q <= s1_q;
      end
   end
   for (genvar i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk_i or posedge rst_i) begin
         if (rst_i) begin
            cnt_q[i] <= 32'h00000000;
            q_o[i] <= 1'b0;
         end else if (s2_q[i] == q_o[i]) begin
            cnt_q[i] <= 32'h00000000;
         end else if (!mask_i[i] || cnt_q[i] >= lim) begin // [RQ12]
            cnt_q[i] <= 32'h00000000;
            q_o[i] <= s2_q[i];
         end else begin
            cnt_q[i] <= cnt_q[i] + 32'h00000001;
         end
      end
   end
endmodule : input_filter

/* File: core/freq_detect.sv */
`timescale 1ns/1ns
module freq_detect (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // frequencies
   input wire logic [15:0] out_i,
   input wire logic [15:0] ref_i,
   input wire logic [15:0] lvl_i,
   input wire logic [15:0] band_i,
   // results for modes one to five
   output logic [4:0] hit_o
);
   logic m4_q;
   wire [16:0] half = {2'b00, band_i[15:1]};
   wire [16:0] lo = ({1'b0, lvl_i} > half) ? {1'b0, lvl_i} - half : 17'h00000;
   wire [16:0] hi = {1'b0, lvl_i} + half;
   function automatic logic in_band(input logic [15:0] f, input logic [16:0] l, input logic [16:0] h);
      in_band = ({1'b0, f} >= l) && ({1'b0, f} <= h);
   endfunction : in_band
   wire ref_in = in_band(ref_i, lo, hi);
   wire out_in = in_band(out_i, lo, hi);
   // =====================================
   // hysteresis for mode four
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         m4_q <= 1'b0;
      end else if (out_i >= lvl_i) begin
         m4_q <= 1'b1; // [RQ17]
      end else if ({1'b0, out_i} < lo) begin
         m4_q <= 1'b0; // [RQ17]
      end
   end
   assign hit_o[0] = (out_i == ref_i); // [RQ14]
   assign hit_o[1] = ref_in && out_in; // [RQ15]
   assign hit_o[2] = out_in; // [RQ16]
   assign hit_o[3] = m4_q;
   assign hit_o[4] = !m4_q; // [RQ18]
endmodule : freq_detect

/* File: core/drive_terminal_io_logic.sv */
// How it works
// RQ1: analog hold freezes output frequency
// RQ2: ramp freeze halts accel and decel
// RQ3: alternate gain selects second proportional gain
// RQ4: three select inputs pick one of five
// RQ5: sequence runs all steps, disable stops it
// RQ6: manual switch honoured only while stopped
// RQ7: step advance moves externally stepped sequence
// RQ8: step hold keeps last step frequency; held only when auto is AUTO_A, under AUTO_B the last step ends in idle
// RQ9: traverse offsets negative or positive
// RQ10: nine-bit input status word
// RQ11: four-bit output status word
// RQ12: input filter time constant times half ms
// RQ13: aux contact follows selected condition
// RQ14: mode one: output reaches reference
// RQ15: mode two: reference and output in band
// RQ16: mode three: output inside band
// RQ17: mode four: level with hysteresis
// RQ18: mode five inverts mode four
// RQ19: overload warning after level for time
// RQ20: all conditions evaluated every cycle
`timescale 1ns/1ns
`include "dtio_consts.svh"
module drive_terminal_io_logic
   import dtio_pkg::*;
#(
   parameter int OL_TICK_CYC = `OL_UNIT_CYC,
   parameter int FILT_TICK_CYC = `FILT_UNIT_CYC
) (
   // clock and reset
   input wire logic CLOCK_I,
   input wire logic RST_I,
   // terminal pins
   input wire logic [5:0] MULTI_INPUT_I,
   input wire logic REVERSE_RUN_INPUT_I,
   input wire logic FORWARD_RUN_INPUT_I,
   input wire logic JOG_INPUT_I,
   input wire logic FAULT_RESET_INPUT_I,
   input wire logic OUTPUT_DISABLE_INPUT_I,
   // drive core
   input wire core_stat_s CORE_I,
   input wire logic [15:0] OUT_FREQ_I,
   input wire logic [15:0] REF_FREQ_I,
   input wire logic [15:0] OUT_CURR_I,
   input wire logic [2:0] OC_REQ_I,
   output drive_ctl_s CTL_O,
   // output terminals
   output logic [2:0] OPEN_COLLECTOR_OUT_O,
   output logic AUX_RELAY_CONTACT_O,
   // parameter port
   input wire logic PAR_WE_I,
   input wire logic [7:0] PAR_ADDR_I,
   input wire logic [15:0] PAR_WDATA_I,
   output logic [15:0] PAR_RDATA_O,
   // status words
   output logic [8:0] IN_STATUS_O,
   output logic [3:0] OUT_STATUS_O
);
   // =====================================
   // parameters
   logic [7:0] filt_q;
   logic [15:0] lvl_q;
   logic [15:0] band_q;
   logic [4:0] aux_sel_q;
   logic [1:0] auto_q;
   logic [15:0] ol_lvl_q;
   logic [15:0] ol_time_q;
   logic [5:0] fn_q [6];
   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         filt_q <= `R_FILT;
         lvl_q <= `R_FDT_LVL;
         band_q <= `R_FDT_BAND;
         aux_sel_q <= `R_AUX_SEL;
         auto_q <= AUTO_OFF;
         ol_lvl_q <= `R_OL_LVL;
         ol_time_q <= `R_OL_TIME;
      end else if (PAR_WE_I) begin
         case (PAR_ADDR_I)
            `A_FILT: filt_q <= PAR_WDATA_I[7:0];
            `A_FDT_LVL: lvl_q <= PAR_WDATA_I;
            `A_FDT_BAND: band_q <= PAR_WDATA_I;
            `A_AUX_SEL: aux_sel_q <= PAR_WDATA_I[4:0];
            `A_AUTO: auto_q <= PAR_WDATA_I[1:0];
            `A_OL_LVL: ol_lvl_q <= PAR_WDATA_I;
            `A_OL_TIME: ol_time_q <= PAR_WDATA_I;
            default: ;
         endcase
      end
   end
   for (genvar i = 0; i < 6; i++) begin : g_fn
      always_ff @(posedge CLOCK_I or posedge RST_I) begin
         if (RST_I) begin
            fn_q[i] <= 6'h00;
         end else if (PAR_WE_I && PAR_ADDR_I == `A_FN_BASE + 8'(i)) begin
            fn_q[i] <= PAR_WDATA_I[5:0];
         end
      end
   end
   // =====================================
   // input filtering
   logic [10:0] t;
   input_filter #(.W(11), .TICK_CYC(FILT_TICK_CYC)) u_filt (
      .clk_i(CLOCK_I),
      .rst_i(RST_I),
      .raw_i({OUTPUT_DISABLE_INPUT_I, FAULT_RESET_INPUT_I, JOG_INPUT_I,
              FORWARD_RUN_INPUT_I, REVERSE_RUN_INPUT_I, MULTI_INPUT_I}),
      .mask_i(`FILT_MASK), // [RQ12]
      .k_i(filt_q),
      .q_o(t)
   );
   function automatic logic fn_on(input logic [5:0] code, input logic [5:0] mi,
                                  input logic [35:0] map);
      fn_on = 1'b0;
      for (int j = 0; j < 6; j++) begin
         if (mi[j] && map[j*6 +: 6] == code) fn_on = 1'b1;
      end
   endfunction : fn_on
   function automatic logic [2:0] seq_num(input logic [2:0] hml);
      case (hml)
         3'h1: seq_num = 3'h1;
         3'h2: seq_num = 3'h2;
         3'h4: seq_num = 3'h3;
         3'h3: seq_num = 3'h4;
         3'h5: seq_num = 3'h5;
         default: seq_num = 3'h0;
      endcase
   endfunction : seq_num
   wire [35:0] map = {fn_q[5], fn_q[4], fn_q[3], fn_q[2], fn_q[1], fn_q[0]};
   wire [5:0] mi = t[5:0];
   wire f_ahold = fn_on(`FN_AHOLD, mi, map);
   wire f_ramp = fn_on(`FN_RAMP, mi, map);
   wire f_gain2 = fn_on(`FN_GAIN2, mi, map);
   wire f_man = fn_on(`FN_MANUAL, mi, map);
   wire f_go = fn_on(`FN_GO, mi, map);
   wire f_hold = fn_on(`FN_HOLD, mi, map);
   wire f_tlo = fn_on(`FN_TRV_LO, mi, map);
   wire f_thi = fn_on(`FN_TRV_HI, mi, map);
   wire [2:0] sel = seq_num({fn_on(`FN_SEQ_H, mi, map), fn_on(`FN_SEQ_M, mi, map),
                             fn_on(`FN_SEQ_L, mi, map)}); // [RQ4]
   wire run_cmd = t[6] | t[7];
   wire bx = t[10];
   // =====================================
   // sequence engine
   typedef enum logic [2:0] {
      S_IDLE = 3'b001,
      S_RUN = 3'b010,
      S_HOLD = 3'b100
   } seq_e;
   seq_e st_q;
   seq_e st_d;
   logic [2:0] step_q;
   logic [2:0] step_d;
   logic [2:0] sel_q;
   logic [2:0] sel_d;
   logic run_p_q;
   logic go_p_q;
   logic manual_q;
   logic step_pls_q;
   logic seq_pls_q;
   wire go_rise = f_go && !go_p_q;
   wire start = run_cmd && !run_p_q && auto_q != AUTO_OFF && !manual_q && sel != 3'h0 && !bx;
   wire adv = (auto_q == AUTO_A) ? CORE_I.step_done : go_rise; // [RQ7]
   wire last = (step_q == 3'h7);
   always_comb begin
      st_d = st_q;
      step_d = step_q;
      sel_d = sel_q;
      case (st_q)
         S_IDLE: begin
            if (start) begin
               st_d = S_RUN;
               step_d = 3'h0;
               sel_d = sel; // [RQ4]
            end
         end
         S_RUN: begin
            if (bx || manual_q) begin
               st_d = S_IDLE; // [RQ5]
            end else if (adv && last) begin
               st_d = (auto_q == AUTO_A && f_hold) ? S_HOLD : S_IDLE; // [RQ5] [RQ8]
            end else if (adv) begin
               step_d = step_q + 3'h1; // [RQ7]
            end
         end
         S_HOLD: begin
            if (bx || !run_cmd) st_d = S_IDLE; // [RQ8]
         end
         default: st_d = S_IDLE;
      endcase
   end
   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         st_q <= S_IDLE;
         step_q <= 3'h0;
         sel_q <= 3'h0;
         run_p_q <= 1'b0;
         go_p_q <= 1'b0;
         step_pls_q <= 1'b0;
         seq_pls_q <= 1'b0;
      end else begin
         st_q <= st_d;
         step_q <= step_d;
         sel_q <= sel_d;
         run_p_q <= run_cmd;
         go_p_q <= f_go;
         step_pls_q <= (st_q == S_RUN) && adv;
         seq_pls_q <= (st_q == S_RUN) && adv && last;
      end
   end
   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         manual_q <= 1'b0;
      end else if (!CORE_I.running) begin
         manual_q <= f_man; // [RQ6]
      end
   end
   // =====================================
   // overload warning timer
   logic [31:0] tick_q;
   logic [15:0] ol_cnt_q;
   wire over = (OUT_CURR_I >= ol_lvl_q);
   wire ol_hit = over && (ol_cnt_q >= ol_time_q); // [RQ19]
   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         tick_q <= 32'h0;
         ol_cnt_q <= 16'h0;
      end else if (!over) begin
         tick_q <= 32'h0; // [RQ19]
         ol_cnt_q <= 16'h0;
      end else if (tick_q >= 32'(OL_TICK_CYC - 1)) begin
         tick_q <= 32'h0;
         if (!ol_hit) ol_cnt_q <= ol_cnt_q + 16'h1;
      end else begin
         tick_q <= tick_q + 32'h1;
      end
   end
   // =====================================
   // aux contact condition
   logic [4:0] fdt;
   freq_detect u_fdt (
      .clk_i(CLOCK_I),
      .rst_i(RST_I),
      .out_i(OUT_FREQ_I),
      .ref_i(REF_FREQ_I),
      .lvl_i(lvl_q),
      .band_i(band_q),
      .hit_o(fdt)
   );
   wire [25:0] cond = {CORE_I.torq, CORE_I.zspd, CORE_I.mmc, CORE_I.trv_dec, CORE_I.trv_acc,
                       CORE_I.ready, seq_pls_q, step_pls_q, CORE_I.ssearch, CORE_I.comm_line,
                       CORE_I.inv_line, CORE_I.steady, !CORE_I.running, CORE_I.running,
                       CORE_I.lost, CORE_I.oh, CORE_I.lv, CORE_I.ov, CORE_I.stall,
                       CORE_I.iol, ol_hit, fdt};
   wire aux_d = (aux_sel_q <= `AUX_MAX) ? cond[aux_sel_q] : 1'b0; // [RQ13] [RQ20]
   // =====================================
   // registered outputs
   drive_ctl_s ctl_d;
   always_comb begin
      ctl_d.freq_hold = f_ahold && CORE_I.ref_analog; // [RQ1]
      ctl_d.ramp_freeze = f_ramp; // [RQ2]
      ctl_d.alt_gain = f_gain2 && CORE_I.closed_loop; // [RQ3]
      ctl_d.manual = manual_q; // [RQ6]
      ctl_d.trv_neg = f_tlo && CORE_I.traverse; // [RQ9]
      ctl_d.trv_pos = f_thi && CORE_I.traverse; // [RQ9]
      ctl_d.fault_reset = t[9];
      ctl_d.out_disable = bx;
      ctl_d.seq_run = (st_d != S_IDLE);
      ctl_d.seq_sel = sel_d;
      ctl_d.seq_step = step_d;
   end
   logic [15:0] rd_d;
   always_comb begin
      case (PAR_ADDR_I)
         `A_IN_STAT: rd_d = {7'h00, t[8:0]};
         `A_OUT_STAT: rd_d = {12'h000, OUT_STATUS_O};
         `A_FILT: rd_d = {8'h00, filt_q};
         `A_FDT_LVL: rd_d = lvl_q;
         `A_FDT_BAND: rd_d = band_q;
         `A_AUX_SEL: rd_d = {11'h000, aux_sel_q};
         `A_AUTO: rd_d = {14'h0000, auto_q};
         `A_OL_LVL: rd_d = ol_lvl_q;
         `A_OL_TIME: rd_d = ol_time_q;
         default: rd_d = (PAR_ADDR_I >= `A_FN_BASE && PAR_ADDR_I < `A_FN_BASE + 8'h06)
                         ? {10'h000, fn_q[3'(PAR_ADDR_I - `A_FN_BASE)]} : 16'h0000;
      endcase
   end
   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         CTL_O <= '0;
         OPEN_COLLECTOR_OUT_O <= 3'h0;
         AUX_RELAY_CONTACT_O <= 1'b0;
         OUT_STATUS_O <= 4'h0;
         IN_STATUS_O <= 9'h000;
         PAR_RDATA_O <= 16'h0000;
      end else begin
         CTL_O <= ctl_d;
         OPEN_COLLECTOR_OUT_O <= OC_REQ_I;
         AUX_RELAY_CONTACT_O <= aux_d; // [RQ13]
         OUT_STATUS_O <= {aux_d, OC_REQ_I}; // [RQ11] [RQ20]
         IN_STATUS_O <= t[8:0]; // [RQ10]
         PAR_RDATA_O <= rd_d;
      end
   end
   // =====================================
   // assertions
   property p_hold;
      @(posedge CLOCK_I) disable iff (RST_I) (f_ahold && CORE_I.ref_analog) |=> CTL_O.freq_hold;
   endproperty
   a_hold: assert property (p_hold) else $error("analog hold not applied"); // [RQ1]
   property p_ramp;
      @(posedge CLOCK_I) disable iff (RST_I) f_ramp |=> CTL_O.ramp_freeze;
   endproperty
   a_ramp: assert property (p_ramp) else $error("ramp freeze missing"); // [RQ2]
   property p_gain;
      @(posedge CLOCK_I) disable iff (RST_I) CTL_O.alt_gain |-> $past(CORE_I.closed_loop);
   endproperty
   a_gain: assert property (p_gain) else $error("alt gain outside closed loop"); // [RQ3]
   property p_start;
      @(posedge CLOCK_I) disable iff (RST_I) (st_q == S_IDLE && start) |=> CTL_O.seq_sel == $past(sel);
   endproperty
   a_start: assert property (p_start) else $error("wrong sequence selected"); // [RQ4]
   property p_bx;
      @(posedge CLOCK_I) disable iff (RST_I) (st_q == S_RUN && bx) |=> st_q == S_IDLE ##1 !CTL_O.seq_run;
   endproperty
   a_bx: assert property (p_bx) else $error("disable did not stop sequence"); // [RQ5]
   property p_man;
      @(posedge CLOCK_I) disable iff (RST_I) CORE_I.running |=> $stable(manual_q);
   endproperty
   a_man: assert property (p_man) else $error("manual changed while running"); // [RQ6]
   property p_go;
      @(posedge CLOCK_I) disable iff (RST_I)
         (st_q == S_RUN && auto_q == AUTO_B && go_rise && !bx && !manual_q && !last)
         |=> step_q == $past(step_q) + 3'h1;
   endproperty
   a_go: assert property (p_go) else $error("step advance missed"); // [RQ7]
   property p_lasthold;
      @(posedge CLOCK_I) disable iff (RST_I)
         (st_q == S_RUN && auto_q == AUTO_A && adv && last && f_hold && !bx && !manual_q)
         |=> st_q == S_HOLD;
   endproperty
   a_lasthold: assert property (p_lasthold) else $error("last step not held"); // [RQ8]
   property p_trv;
      @(posedge CLOCK_I) disable iff (RST_I) (CTL_O.trv_neg || CTL_O.trv_pos) |-> $past(CORE_I.traverse);
   endproperty
   a_trv: assert property (p_trv) else $error("offset outside traverse"); // [RQ9]
   property p_in;
      @(posedge CLOCK_I) disable iff (RST_I) ##1 IN_STATUS_O == $past(t[8:0]);
   endproperty
   a_in: assert property (p_in) else $error("input status mismatch"); // [RQ10]
   property p_out;
      @(posedge CLOCK_I) disable iff (RST_I) OUT_STATUS_O[3] == AUX_RELAY_CONTACT_O;
   endproperty
   a_out: assert property (p_out) else $error("out status bit 3 differs"); // [RQ11]
   property p_fdt5;
      @(posedge CLOCK_I) disable iff (RST_I) (aux_sel_q == 5'h04) |=> AUX_RELAY_CONTACT_O == !$past(fdt[3]);
   endproperty
   a_fdt5: assert property (p_fdt5) else $error("mode five not inverted"); // [RQ18]
   property p_ol;
      @(posedge CLOCK_I) disable iff (RST_I) (!over ##1 over) |-> !ol_hit || ol_time_q == 16'h0;
   endproperty
   a_ol: assert property (p_ol) else $error("overload warning too early"); // [RQ19]
   c_seq: cover property (@(posedge CLOCK_I) disable iff (RST_I) seq_pls_q);
   c_hold: cover property (@(posedge CLOCK_I) disable iff (RST_I) st_q == S_HOLD);
   c_ol: cover property (@(posedge CLOCK_I) disable iff (RST_I) ol_hit);
endmodule : drive_terminal_io_logic

/* File: test/terminal_model.sv */
`timescale 1ns/1ns
module terminal_model (
   // bench side
   input wire logic [10:0] want_i,
   input wire logic glitch_i,
   // device side
   input wire logic aux_i,
   output logic [10:0] pins_o,
   output logic lamp_o
);
   // ====================
   // contacts: jog contact chatters on command
   assign pins_o = want_i ^ {2'h0, glitch_i, 8'h00};
   // bit 10 is the disable contact; it and manual mode are the two early stops of a sequence
   // ====================
   // relay load
   assign lamp_o = aux_i;
endmodule : terminal_model

/* File: test/test_drive_terminal_io_logic.sv */
`timescale 1ns/1ns
`include "dtio_consts.svh"
module test_drive_terminal_io_logic;
   import dtio_pkg::*;
   // ====================
   // signals
   typedef struct packed {
      logic [4:0] sel;
      logic run;
      logic [2:0] oc;
      logic [15:0] fo;
      logic [15:0] fr;
      logic aux;
   } row_s;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [10:0] want = 11'h000;
   logic glitch = 1'b0;
   logic [10:0] pins;
   logic lamp;
   core_stat_s core = '0;
   logic [15:0] fout = 16'h0000;
   logic [15:0] fref = 16'h0000;
   logic [15:0] curr = 16'h0000;
   logic [2:0] oc = 3'h0;
   drive_ctl_s ctl;
   logic [2:0] oco;
   logic aux;
   logic we = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [15:0] wdata = 16'h0000;
   logic [15:0] rdata;
   logic [8:0] ins;
   logic [3:0] outs;
   int n_errors = 0;
   int n_checks = 0;
   int ticks = 0;
   int i;
   int s;
   row_s rows [17] = '{
      '{5'h00, 1'b0, 3'h1, 16'h03E8, 16'h03E8, 1'b1}, '{5'h00, 1'b0, 3'h2, 16'h03E8, 16'h03E9, 1'b0},
      '{5'h01, 1'b0, 3'h4, 16'h09C4, 16'h0DAC, 1'b1}, '{5'h01, 1'b0, 3'h0, 16'h09C3, 16'h0BB8, 1'b0},
      '{5'h01, 1'b0, 3'h0, 16'h0BB8, 16'h0DAD, 1'b0}, '{5'h02, 1'b0, 3'h0, 16'h0DAC, 16'h0000, 1'b1},
      '{5'h02, 1'b0, 3'h0, 16'h0DAD, 16'h0000, 1'b0}, '{5'h03, 1'b0, 3'h0, 16'h0BB8, 16'h0000, 1'b1},
      '{5'h03, 1'b0, 3'h0, 16'h0A28, 16'h0000, 1'b1}, '{5'h04, 1'b0, 3'h0, 16'h0A28, 16'h0000, 1'b0},
      '{5'h03, 1'b0, 3'h0, 16'h09C3, 16'h0000, 1'b0}, '{5'h03, 1'b0, 3'h0, 16'h0A28, 16'h0000, 1'b0},
      '{5'h04, 1'b0, 3'h0, 16'h0A28, 16'h0000, 1'b1}, '{5'h0C, 1'b1, 3'h7, 16'h0000, 16'h0000, 1'b1},
      '{5'h0C, 1'b0, 3'h0, 16'h0000, 16'h0000, 1'b0}, '{5'h0D, 1'b0, 3'h0, 16'h0000, 16'h0000, 1'b1},
      '{5'h1A, 1'b1, 3'h0, 16'h0000, 16'h0000, 1'b0}};
   logic [5:0] fcode [6] = '{`FN_AHOLD, `FN_RAMP, `FN_GAIN2, `FN_MANUAL, `FN_TRV_LO, `FN_TRV_HI};
   logic [5:0] fmask [6] = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h02, 6'h01};
   logic [2:0] combo [5] = '{3'h1, 3'h2, 3'h4, 3'h3, 3'h5};
   // ====================
   // clock, contacts and device
   initial begin
      forever #2 clk = ~clk;
   end
   terminal_model PARTNER (.want_i(want), .glitch_i(glitch), .aux_i(aux), .pins_o(pins), .lamp_o(lamp));
   drive_terminal_io_logic #(.OL_TICK_CYC(10), .FILT_TICK_CYC(125)) DUT (
      .CLOCK_I(clk), .RST_I(rst), .MULTI_INPUT_I(pins[5:0]), .REVERSE_RUN_INPUT_I(pins[6]),
      .FORWARD_RUN_INPUT_I(pins[7]), .JOG_INPUT_I(pins[8]), .FAULT_RESET_INPUT_I(pins[9]),
      .OUTPUT_DISABLE_INPUT_I(pins[10]), .CORE_I(core), .OUT_FREQ_I(fout), .REF_FREQ_I(fref),
      .OUT_CURR_I(curr), .OC_REQ_I(oc), .CTL_O(ctl), .OPEN_COLLECTOR_OUT_O(oco),
      .AUX_RELAY_CONTACT_O(aux), .PAR_WE_I(we), .PAR_ADDR_I(addr), .PAR_WDATA_I(wdata),
      .PAR_RDATA_O(rdata), .IN_STATUS_O(ins), .OUT_STATUS_O(outs));
   // ====================
   // tasks
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask : cyc
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      cyc(1);
      addr = a;
      wdata = d;
      we = 1'b1;
      cyc(1);
      we = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      addr = a;
      cyc(2);
      chk("read data", exp, rdata);
   endtask : rd
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : end_of_test
   always @(posedge clk) begin
      ticks++;
      if (ticks == 20000) begin
         n_errors++;
         end_of_test();
      end
   end
   // ====================
   // main sequence
   initial begin
      cyc(4);
      chk("status in reset", 16'h0000, 16'(outs));
      cyc(4);
      rst = 1'b0;
      rd(`A_AUX_SEL, 16'h000C);
      rd(`A_FILT, 16'h000F);
      wr(`A_OUT_STAT, 16'h000F);
      rd(`A_OUT_STAT, 16'h0000);
      rd(8'hFF, 16'h0000);
      $display("test reset done");
      glitch = 1'b1;
      cyc(5);
      glitch = 1'b0;
      cyc(5);
      want[8] = 1'b1;
      cyc(1850);
      chk("jog early", 16'h0000, 16'(ins));
      cyc(40);
      chk("jog status", 16'h0100, 16'(ins));
      rd(`A_IN_STAT, 16'h0100);
      wr(`A_FILT, 16'h0000);
      want[8] = 1'b0;
      cyc(8);
      $display("test filter done");
      for (i = 0; i < 17; i++) begin
         wr(`A_AUX_SEL, 16'(rows[i].sel));
         core.running = rows[i].run;
         oc = rows[i].oc;
         fout = rows[i].fo;
         fref = rows[i].fr;
         cyc(4);
         chk("aux", 16'(rows[i].aux), 16'(aux));
         chk("out status", 16'({rows[i].aux, rows[i].oc}), 16'(outs));
         chk("oc out", 16'(rows[i].oc), 16'(oco));
         chk("lamp", 16'(rows[i].aux), 16'(lamp));
      end
      $display("test aux table done");
      wr(`A_OL_LVL, 16'h0064);
      wr(`A_OL_TIME, 16'h0002);
      wr(`A_AUX_SEL, 16'h0005);
      curr = 16'h0064;
      cyc(15);
      chk("overload early", 16'h0000, 16'(aux));
      cyc(12);
      chk("overload", 16'h0001, 16'(aux));
      curr = 16'h0063;
      cyc(3);
      chk("overload drop", 16'h0000, 16'(aux));
      $display("test overload done");
      core.running = 1'b0;
      core.ref_analog = 1'b1;
      core.closed_loop = 1'b1;
      core.traverse = 1'b1;
      for (i = 0; i < 6; i++) begin
         wr(`A_FN_BASE + 8'h03, 16'(fcode[i]));
         want[3] = 1'b1;
         cyc(6);
         chk("function on", 16'(fmask[i]), 16'(ctl[14:9]));
         chk("p4 status", 16'h0008, 16'(ins));
         want[3] = 1'b0;
         cyc(6);
         chk("function off", 16'h0000, 16'(ctl[14:9]));
      end
      wr(`A_FN_BASE + 8'h03, 16'(`FN_MANUAL));
      core.running = 1'b1;
      want[3] = 1'b1;
      cyc(6);
      chk("manual running", 16'h0000, 16'(ctl.manual));
      core.running = 1'b0;
      cyc(6);
      chk("manual stopped", 16'h0001, 16'(ctl.manual));
      want[3] = 1'b0;
      wr(`A_FN_BASE + 8'h03, 16'h0000);
      $display("test functions done");
      wr(`A_FN_BASE, 16'(`FN_SEQ_L));
      wr(`A_FN_BASE + 8'h01, 16'(`FN_SEQ_M));
      wr(`A_FN_BASE + 8'h02, 16'(`FN_SEQ_H));
      wr(`A_FN_BASE + 8'h04, 16'(`FN_GO));
      wr(`A_FN_BASE + 8'h05, 16'(`FN_HOLD));
      wr(`A_AUTO, 16'h0002);
      for (i = 0; i < 5; i++) begin
         want[2:0] = combo[i];
         cyc(6);
         want[7] = 1'b1;
         cyc(6);
         chk("sequence", 16'({1'b1, 3'(i + 1), 3'h0}), 16'(ctl[6:0]));
         for (s = 1; s < 9; s++) begin
            want[4] = 1'b1;
            cyc(6);
            want[4] = 1'b0;
            cyc(6);
            chk("step", (s < 8) ? 16'(s) : 16'h0007, 16'(ctl.seq_step));
            chk("running", (s < 8) ? 16'h0001 : 16'h0000, 16'(ctl.seq_run));
         end
         want[7] = 1'b0;
         cyc(6);
      end
      want[7] = 1'b1;
      cyc(6);
      want[10:9] = 2'h3;
      cyc(6);
      chk("disable stop", 16'h0000, 16'(ctl.seq_run));
      chk("disable and reset", 16'h0003, 16'(ctl[8:7]));
      want[10:9] = 2'h0;
      want[7] = 1'b0;
      wr(`A_AUTO, 16'h0001);
      want[5] = 1'b1;
      want[7] = 1'b1;
      cyc(6);
      for (s = 0; s < 8; s++) begin
         core.step_done = 1'b1;
         cyc(1);
         core.step_done = 1'b0;
         cyc(4);
      end
      chk("hold last step", 16'h0001, 16'(ctl.seq_run));
      want[7] = 1'b0;
      cyc(6);
      chk("hold released", 16'h0000, 16'(ctl.seq_run));
      $display("test sequence done");
      end_of_test();
   end
endmodule : test_drive_terminal_io_logic
